/* File: hw/code_map_defines.vh */
// Purpose: constants for the program memory map and pointer register bank
// Assumes: apb byte address = 4 * special function index; bit 10 picks indirect ram
// Notes: all offsets, reset values, vectors and field positions live here
`ifndef CODE_MAP_DEFINES_VH
`define CODE_MAP_DEFINES_VH

// special function indexes and their reset values
`define IDX_STACK_TOP 8'h81
`define IDX_TABLE_LOW 8'h82
`define IDX_TABLE_HIGH 8'h83
`define IDX_CTRL_STATUS 8'h90
`define IDX_PGM_COMMAND 8'h94
`define IDX_PGM_TARGET_LOW 8'h95
`define IDX_PGM_TARGET_HIGH 8'h96
`define IDX_PGM_SOURCE_RAM 8'h97
`define RST_STACK_TOP 8'h07
`define RST_TABLE_LOW 8'h00
`define RST_TABLE_HIGH 8'h00
`define RST_ZERO_BYTE 8'h00

// control and status fields at the control index, and the go code for the command index
`define BIT_PROTECT 0
`define BIT_BUSY 4
`define BIT_DONE 5
`define BIT_REJECT 6
`define PGM_GO_CODE 8'h5A

// program memory map
`define ADDR_RESET 16'h0000
`define ADDR_RESET_CODE_LO 16'h0001
`define ADDR_RESET_CODE_HI 16'h0002
`define ADDR_VECTOR_LO 16'h0003
`define ADDR_VECTOR_HI 16'h00EB
`define ADDR_PGM_LO 16'h00EC
`define ADDR_PGM_HI 16'h0FDF
`define ADDR_NO_PGM_LO 16'h0FE0
`define ADDR_RESERVED_LO 16'h0FF6
`define ADDR_RESERVED_HI 16'h0FFF

// interrupt event numbers and their entry addresses
`define IRQ_EXT_ZERO 4'h0
`define IRQ_TIMER_ZERO 4'h1
`define IRQ_EXT_ONE 4'h2
`define IRQ_TIMER_ONE 4'h3
`define IRQ_SERIAL 4'h4
`define IRQ_EXT_TWO 4'h5
`define IRQ_CONVERTER 4'h6
`define IRQ_TIMER_THREE 4'h7
`define VEC_EXT_ZERO 16'h0003
`define VEC_TIMER_ZERO 16'h000B
`define VEC_EXT_ONE 16'h0013
`define VEC_TIMER_ONE 16'h001B
`define VEC_SERIAL 16'h0023
`define VEC_EXT_TWO 16'h0083
`define VEC_CONVERTER 16'h008B
`define VEC_TIMER_THREE 16'h00EB

// upper half boundary of the internal scratch ram and the apb address bit that picks it
`define UPPER_HALF 8'h80
`define APB_INDIRECT_BIT 10

`endif

/* File: hw/code_map.v */
// Purpose: program memory region classifier and interrupt vector lookup
// Assumes: pure combinational, used by the pointer bank
// Notes: unknown event numbers give no valid vector
`include "code_map_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module code_map (
	input wire [15:0] addr,
	input wire [3:0] irq_num,
	output reg [15:0] vector,
	output reg vector_ok,
	output wire in_reset_code,
	output wire in_vector_area,
	output wire selfprog_ok,
	output wire in_reserved
);
	// region decode of a program address
	assign in_reset_code = (addr >= `ADDR_RESET_CODE_LO) && (addr <= `ADDR_RESET_CODE_HI);
	assign in_vector_area = (addr >= `ADDR_VECTOR_LO) && (addr <= `ADDR_VECTOR_HI);
	assign selfprog_ok = (addr >= `ADDR_PGM_LO) && (addr <= `ADDR_PGM_HI);
	assign in_reserved = (addr >= `ADDR_RESERVED_LO) && (addr <= `ADDR_RESERVED_HI);

	// fixed entry address per event
	always @* begin
		vector_ok = 1'b1;
		case (irq_num)
			`IRQ_EXT_ZERO: vector = `VEC_EXT_ZERO;
			`IRQ_TIMER_ZERO: vector = `VEC_TIMER_ZERO;
			`IRQ_EXT_ONE: vector = `VEC_EXT_ONE;
			`IRQ_TIMER_ONE: vector = `VEC_TIMER_ONE;
			`IRQ_SERIAL: vector = `VEC_SERIAL;
			`IRQ_EXT_TWO: vector = `VEC_EXT_TWO;
			`IRQ_CONVERTER: vector = `VEC_CONVERTER;
			`IRQ_TIMER_THREE: vector = `VEC_TIMER_THREE;
			default: begin
				vector = `ADDR_RESET;
				vector_ok = 1'b0;
			end
		endcase
	end
endmodule // code_map
`default_nettype wire

/* File: hw/pointer_bank.v */
// Purpose: stack and table pointers, self programming registers, code map
// Assumes: apb slave with one wait state; cpu ports synchronous to pclk
// Notes: indirect ram covers only the upper half; lower half is elsewhere
//
// Register access over APB was decided locally.
`include "code_map_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module pointer_bank #(
	parameter RAM_DEPTH = 128,
	parameter [7:0] GO_CODE = `PGM_GO_CODE
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire bit_req,
	input wire [7:0] bit_addr,
	input wire [1:0] bit_op,
	output reg bit_value,
	output reg bit_ack,
	output reg bit_err,
	input wire irq_take,
	input wire [3:0] irq_num,
	output reg [15:0] vector_addr,
	output reg vector_valid,
	output reg [15:0] pc_reset_value,
	output reg pc_load,
	output reg [15:0] table_addr,
	output reg [7:0] stack_top_pointer,
	output reg selfprog_start,
	output reg [15:0] selfprog_addr,
	output reg [7:0] selfprog_ram,
	input wire selfprog_done,
	input wire dump_req,
	input wire [7:0] flash_rdata,
	output reg [7:0] dump_data,
	output reg dump_valid
);
	// bit operation codes
	localparam [1:0] OP_TEST = 2'b00;
	localparam [1:0] OP_SET = 2'b01;
	localparam [1:0] OP_CLEAR = 2'b10;

	reg [7:0] table_pointer_low;
	reg [7:0] table_pointer_high;
	reg [7:0] selfprog_command;
	reg [7:0] selfprog_target_low;
	reg [7:0] selfprog_target_high;
	reg [7:0] selfprog_source_ram;
	reg protect;
	reg busy;
	reg done;
	reg reject;
	reg [7:0] scratch [0:RAM_DEPTH-1];
	reg [7:0] next_rdata;
	reg next_err;
	reg [7:0] ctrl_byte;
	reg [7:0] bit_byte;
	reg bit_map_ok;

	wire [15:0] target = {selfprog_target_high, selfprog_target_low};
	wire [15:0] map_vector;
	wire map_vector_ok;
	wire target_ok;
	wire [7:0] idx = paddr[9:2];
	wire indirect = paddr[`APB_INDIRECT_BIT];
	wire in_upper = idx >= `UPPER_HALF;
	wire [6:0] ram_idx = idx[6:0];
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite & ~pslverr;
	wire wr_direct = wr & ~indirect;

	// bit operation decode: byte address is the bit address with low three bits cleared
	wire [7:0] bit_byte_addr = {bit_addr[7:3], 3'b000};
	wire [2:0] bit_pos = bit_addr[2:0];
	wire bit_ok = bit_req & bit_addr[7] & bit_map_ok;
	wire bit_set_ctl = bit_ok & (bit_op == OP_SET) & (bit_byte_addr == `IDX_CTRL_STATUS);
	wire bit_clr_ctl = bit_ok & (bit_op == OP_CLEAR) & (bit_byte_addr == `IDX_CTRL_STATUS);

	// self programming command is decoded when the go code lands in the command index
	wire cmd_wr = wr_direct & (idx == `IDX_PGM_COMMAND);
	wire cmd_go = cmd_wr & (pwdata[7:0] == GO_CODE);
	wire ctl_wr = wr_direct & (idx == `IDX_CTRL_STATUS);

	// launch and refusal are exclusive for a go write; clears come from either path
	wire launch = cmd_go & ~busy & target_ok;
	wire refuse = cmd_go & (busy | ~target_ok);
	wire done_clear = (ctl_wr & pwdata[`BIT_DONE]) | (bit_clr_ctl & (bit_pos == `BIT_DONE));
	wire reject_clear = (ctl_wr & pwdata[`BIT_REJECT]) | (bit_clr_ctl & (bit_pos == `BIT_REJECT));
	wire protect_set = (ctl_wr & pwdata[`BIT_PROTECT]) | (bit_set_ctl & (bit_pos == `BIT_PROTECT));
	wire ram_we = wr & indirect & in_upper;

	code_map u_map (
		.addr(target),
		.irq_num(irq_num),
		.vector(map_vector),
		.vector_ok(map_vector_ok),
		.in_reset_code(),
		.in_vector_area(),
		.selfprog_ok(target_ok),
		.in_reserved()
	);

	// control and status byte as software sees it
	always @* begin
		ctrl_byte = `RST_ZERO_BYTE;
		ctrl_byte[`BIT_PROTECT] = protect;
		ctrl_byte[`BIT_BUSY] = busy;
		ctrl_byte[`BIT_DONE] = done;
		ctrl_byte[`BIT_REJECT] = reject;
	end

	// which byte a bit operation reaches; only implemented bit addressable bytes answer
	always @* begin
		bit_byte = `RST_ZERO_BYTE;
		bit_map_ok = 1'b0;
		case (bit_byte_addr)
			`IDX_CTRL_STATUS: begin
				bit_byte = ctrl_byte;
				bit_map_ok = 1'b1;
			end
			default: begin
				bit_byte = `RST_ZERO_BYTE;
				bit_map_ok = 1'b0;
			end
		endcase
	end

	// read data and error for the current apb access
	// unmapped direct indexes answer with an error so a wrong offset shows
	always @* begin
		next_rdata = `RST_ZERO_BYTE;
		next_err = 1'b0;
		if (indirect) begin
			if (in_upper) begin
				next_rdata = scratch[ram_idx];
			end else begin
				next_err = 1'b1;
			end
		end else begin
			case (idx)
				`IDX_STACK_TOP: next_rdata = stack_top_pointer;
				`IDX_TABLE_LOW: next_rdata = table_pointer_low;
				`IDX_TABLE_HIGH: next_rdata = table_pointer_high;
				`IDX_CTRL_STATUS: next_rdata = ctrl_byte;
				`IDX_PGM_COMMAND: next_rdata = selfprog_command;
				`IDX_PGM_TARGET_LOW: next_rdata = selfprog_target_low;
				`IDX_PGM_TARGET_HIGH: next_rdata = selfprog_target_high;
				`IDX_PGM_SOURCE_RAM: next_rdata = selfprog_source_ram;
				default: next_err = 1'b1;
			endcase
		end
	end

	// apb handshake: one wait state, so every answer comes from a flop
	// a master that holds penable past the answer sees pready drop, then a
	// second pulse on the next edge; the repeat answer needs no fresh setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel & penable & ~pready) begin
			pready <= 1'b1;
			prdata <= {24'h000000, next_rdata};
			pslverr <= next_err;
		end else begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// pointer registers written directly by software
	// writes land only on the edge where pready is seen, never on an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_top_pointer <= `RST_STACK_TOP;
			table_pointer_low <= `RST_TABLE_LOW;
			table_pointer_high <= `RST_TABLE_HIGH;
		end else if (wr_direct) begin
			if (idx == `IDX_STACK_TOP)
				stack_top_pointer <= pwdata[7:0];
			if (idx == `IDX_TABLE_LOW)
				table_pointer_low <= pwdata[7:0];
			if (idx == `IDX_TABLE_HIGH)
				table_pointer_high <= pwdata[7:0];
		end
	end

	// table read address follows the two pointer bytes one cycle later
	// the extra flop keeps the fetch address clean; software sees the
	// new pointer one cycle before the core does
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			table_addr <= {`RST_TABLE_HIGH, `RST_TABLE_LOW};
		else
			table_addr <= {table_pointer_high, table_pointer_low};
	end

	// self programming address and source registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selfprog_command <= `RST_ZERO_BYTE;
			selfprog_target_low <= `RST_ZERO_BYTE;
			selfprog_target_high <= `RST_ZERO_BYTE;
			selfprog_source_ram <= `RST_ZERO_BYTE;
		end else if (wr_direct) begin
			if (idx == `IDX_PGM_COMMAND)
				selfprog_command <= pwdata[7:0];
			if (idx == `IDX_PGM_TARGET_LOW)
				selfprog_target_low <= pwdata[7:0];
			if (idx == `IDX_PGM_TARGET_HIGH)
				selfprog_target_high <= pwdata[7:0];
			if (idx == `IDX_PGM_SOURCE_RAM)
				selfprog_source_ram <= pwdata[7:0];
		end
	end

	// launch only inside the programmable window; anything else is refused, which
	// also shields the upper code and the reserved top from a misbehaving program
	// refusal shows in the reject flag rather than as a bus error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selfprog_start <= 1'b0;
			selfprog_addr <= `ADDR_RESET;
			selfprog_ram <= `RST_ZERO_BYTE;
			busy <= 1'b0;
		end else begin
			selfprog_start <= 1'b0;
			if (launch) begin
				selfprog_start <= 1'b1;
				selfprog_addr <= target;
				selfprog_ram <= selfprog_source_ram;
				busy <= 1'b1;
			end else if (selfprog_done) begin
				busy <= 1'b0;
			end
		end
	end

	// sticky status: hardware set wins over a software clear in the same cycle
	// reject covers both causes: engine still busy or target outside the window
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
			reject <= 1'b0;
		end else begin
			if (busy & selfprog_done)
				done <= 1'b1;
			else if (done_clear)
				done <= 1'b0;
			if (refuse)
				reject <= 1'b1;
			else if (reject_clear)
				reject <= 1'b0;
		end
	end

	// protection can be switched on but never off until the next reset
	// software cannot withdraw it, so a locked part stays locked until reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			protect <= 1'b0;
		else if (protect_set)
			protect <= 1'b1;
	end

	// external read out; protected parts give only zero bytes
	// the locked path answers with the same timing, so a reader cannot
	// tell a blank part from a locked one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dump_data <= `RST_ZERO_BYTE;
			dump_valid <= 1'b0;
		end else begin
			dump_valid <= dump_req;
			if (dump_req)
				dump_data <= protect ? `RST_ZERO_BYTE : flash_rdata;
		end
	end

	// single bit test, set and clear
	// only the control byte answers; other upper bytes live outside this bank
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_value <= 1'b0;
			bit_ack <= 1'b0;
			bit_err <= 1'b0;
		end else begin
			bit_ack <= bit_req;
			bit_err <= bit_req & ~bit_ok;
			if (bit_ok)
				bit_value <= bit_byte[bit_pos];
		end
	end

	// interrupt entry address handed to the core when an event is taken
	// unknown event numbers keep the last address and give no strobe
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_addr <= `ADDR_RESET;
			vector_valid <= 1'b0;
		end else begin
			vector_valid <= irq_take & map_vector_ok;
			if (irq_take & map_vector_ok)
				vector_addr <= map_vector;
		end
	end

	// any reset, whatever its source, arrives here as presetn
	// the load strobe spans the whole reset and one edge after it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reset_value <= `ADDR_RESET;
			pc_load <= 1'b1;
		end else begin
			pc_reset_value <= `ADDR_RESET;
			pc_load <= 1'b0;
		end
	end

	// upper half scratch ram, reached only by indirect accesses
	// the lower half sits in the core; an indirect access there is refused
	genvar g;
	generate
		for (g = 0; g < RAM_DEPTH; g = g + 1) begin : g_ram
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					scratch[g] <= `RST_ZERO_BYTE;
				else if (ram_we & (ram_idx == g))
					scratch[g] <= pwdata[7:0];
			end
		end
	endgenerate
endmodule // pointer_bank
`default_nettype wire

/* File: test/pointer_bank_props.sv */
// Purpose: port level checks on the pointer bank
// Assumes: one clock domain, async active low reset
// Notes: vector table kept here by hand, not shared with the bench
`timescale 1ns/1ps
`default_nettype none
module pointer_bank_props #(
	parameter [7:0] GO_CODE = 8'h5A
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bit_req,
	input wire logic [7:0] bit_addr,
	input wire logic bit_ack,
	input wire logic bit_err,
	input wire logic irq_take,
	input wire logic [3:0] irq_num,
	input wire logic [15:0] vector_addr,
	input wire logic vector_valid,
	input wire logic [15:0] pc_reset_value,
	input wire logic pc_load,
	input wire logic selfprog_start,
	input wire logic [15:0] selfprog_addr
);
	localparam logic [15:0] VT [8] = '{16'h3, 16'hB, 16'h13, 16'h1B, 16'h23, 16'h83, 16'h8B, 16'hEB};
	wire logic go_w;
	// go code landing on the command index at the write edge
	assign go_w = psel && penable && pready && pwrite && paddr == 12'h250 && pwdata[7:0] == GO_CODE;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_req; psel && penable && !pready; endsequence
	sequence s_go; go_w ##1 selfprog_start; endsequence
	property p_pc; pc_load && presetn |-> pc_reset_value == 16'h0 ##1 !pc_load; endproperty
	a_pc: assert property (p_pc) else $error("bad reset entry");
	property p_irq; irq_take && irq_num < 4'h8 |=> vector_valid && vector_addr == VT[$past(irq_num)];
	endproperty
	a_irq: assert property (p_irq) else $error("bad vector");
	property p_noirq; irq_take && irq_num > 4'h7 |=> !vector_valid; endproperty
	a_noirq: assert property (p_noirq) else $error("vector for no event");
	property p_ready; s_req |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no bus answer");
	property p_refuse; s_req ##0 paddr[10] && !paddr[9] |=> pready && pslverr && prdata == 32'h0;
	endproperty
	a_refuse: assert property (p_refuse) else $error("low ram not refused");
	property p_berr; bit_req && bit_addr[7:3] != 5'h12 |=> bit_ack && bit_err; endproperty
	a_berr: assert property (p_berr) else $error("bit op not refused");
	property p_cause; selfprog_start |-> $past(go_w); endproperty
	a_cause: assert property (p_cause) else $error("start without go");
	// a start is one cycle long and only ever inside the writable span
	property p_range; s_go |-> selfprog_addr >= 16'hEC && selfprog_addr <= 16'hFDF ##1 !selfprog_start;
	endproperty
	a_range: assert property (p_range) else $error("start out of span");
endmodule // pointer_bank_props
`default_nettype wire

/* File: test/cpu_side_model.sv */
// Purpose: stand-in for the cpu core and programming engine
// Assumes: one engine run per start pulse
// Notes: read data moves every cycle, so a stale capture shows
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic selfprog_start,
	input wire logic slow,
	output logic selfprog_done,
	output logic [7:0] flash_rdata
);
	logic [4:0] left;
	// engine run, short or long as the bench picks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 5'h00;
			selfprog_done <= 1'h0;
			flash_rdata <= 8'hA5;
		end else begin
			selfprog_done <= left == 5'h01;
			flash_rdata <= flash_rdata + 8'h3B;
			if (selfprog_start)
				left <= slow ? 5'h1E : 5'h02;
			else if (left != 5'h00)
				left <= left - 5'h01;
		end
	end
endmodule // cpu_side_model
`default_nettype wire

/* File: test/tb_program_memory_map_and_pointers.sv */
// Purpose: self-checking bench for the pointer bank
// Assumes: apb byte address is four times the index
// Notes: random data from a fixed seed, corners by hand
`timescale 1ns/1ps
`default_nettype none
`include "code_map_defines.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); end end
module tb_program_memory_map_and_pointers;
	logic pclk, presetn, psel, penable, pwrite, bit_req, irq_take, dump_req, slow, er;
	logic pready, pslverr, bit_value, bit_ack, bit_err, vector_valid, pc_load;
	logic selfprog_start, selfprog_done, dump_valid;
	logic [1:0] bit_op;
	logic [3:0] irq_num;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] bit_addr, flash_rdata, dump_data, stack_top_pointer, selfprog_ram, fr, v [3];
	logic [15:0] vector_addr, pc_reset_value, table_addr, selfprog_addr, t;
	int failures, cmp_count, cycles;
	localparam logic [15:0] VT [8] = '{16'h3, 16'hB, 16'h13, 16'h1B, 16'h23, 16'h83, 16'h8B, 16'hEB};
	localparam logic [15:0] TT [6] = '{16'hEB, 16'hEC, 16'hFDF, 16'hFE0, 16'hFF6, 16'hFFF};
	pointer_bank DUT (.*);
	cpu_side_model CPU (.*);
	// free running clock
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		// wait for the answer; only the hang guard ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input logic ee);
		apb(1'h0, a, 8'h00);
		`CHK("prdata", {24'h000000, e}, rd)
		`CHK("pslverr", ee, er)
	endtask
	task automatic bitop(input logic [7:0] a, input logic [1:0] op, input logic ee, input logic ev);
		@(posedge pclk);
		bit_req <= 1'h1;
		bit_addr <= a;
		bit_op <= op;
		@(posedge pclk);
		bit_req <= 1'h0;
		#1;
		`CHK("bit_ack", 1'h1, bit_ack)
		`CHK("bit_err", ee, bit_err)
		if (op == 2'h0 && !ee) `CHK("bit_value", ev, bit_value)
	endtask
	task automatic dump(input logic z);
		@(posedge pclk);
		dump_req <= 1'h1;
		@(posedge pclk);
		dump_req <= 1'h0;
		fr = z ? 8'h00 : flash_rdata;
		#1;
		`CHK("dump_valid", 1'h1, dump_valid)
		`CHK("dump_data", fr, dump_data)
	endtask
	task automatic go(input logic [15:0] a, input logic ok);
		logic [7:0] r;
		r = 8'($urandom);
		apb(1'h1, 12'h254, a[7:0]);
		apb(1'h1, 12'h258, a[15:8]);
		apb(1'h1, 12'h25C, r);
		apb(1'h1, 12'h250, `PGM_GO_CODE);
		#1;
		`CHK("start", ok, selfprog_start)
		if (ok) `CHK("target", a, selfprog_addr)
		if (ok) `CHK("source", r, selfprog_ram)
	endtask
	// poll until idle, then check and clear done and reject
	task automatic finish(input logic [1:0] f);
		int n;
		n = 0;
		do begin
			apb(1'h0, 12'h240, 8'h00);
			n++;
		end while (rd[4] !== 1'h0 && n < 20);
		`CHK("flags", f, rd[6:5])
		apb(1'h1, 12'h240, 8'h60);
	endtask
	// main sequence
	initial begin
		{psel, penable, pwrite, bit_req, irq_take, dump_req, slow, presetn} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		bit_addr = 8'h00;
		bit_op = 2'h0;
		irq_num = 4'h0;
		void'($urandom(32'hE382));
		repeat (5) @(posedge pclk);
		`CHK("pc_load", 1'h1, pc_load)
		`CHK("stack", 8'h07, stack_top_pointer)
		presetn <= 1'h1;
		@(posedge pclk);
		#1;
		`CHK("pc_load", 1'h0, pc_load)
		`CHK("pc_reset", 16'h0000, pc_reset_value)
		rdchk(12'h204, 8'h07, 1'h0);
		rdchk(12'h208, 8'h00, 1'h0);
		rdchk(12'h20C, 8'h00, 1'h0);
		for (int i = 0; i < 3; i++) begin
			v[i] = 8'($urandom);
			apb(1'h1, 12'(12'h204 + 4 * i), v[i]);
		end
		for (int i = 0; i < 3; i++) rdchk(12'(12'h204 + 4 * i), v[i], 1'h0);
		`CHK("table_addr", {v[2], v[1]}, table_addr)
		`CHK("stack", v[0], stack_top_pointer)
		rdchk(12'h210, 8'h00, 1'h1);
		rdchk(12'h440, 8'h00, 1'h1);
		fr = 8'h80 | 8'($urandom);
		apb(1'h1, {2'h1, fr, 2'h0}, v[1]);
		rdchk({2'h1, fr, 2'h0}, v[1], 1'h0);
		rdchk(12'h204, v[0], 1'h0);
		for (int i = 0; i < 9; i++) begin
			@(posedge pclk);
			irq_take <= 1'h1;
			irq_num <= 4'(i);
			@(posedge pclk);
			irq_take <= 1'h0;
			#1;
			`CHK("vector_valid", i < 8, vector_valid)
			if (i < 8) `CHK("vector_addr", VT[i], vector_addr)
		end
		dump(1'h0);
		bitop(8'h90, 2'h0, 1'h0, 1'h0);
		bitop(8'h90, 2'h1, 1'h0, 1'h0);
		bitop(8'h90, 2'h0, 1'h0, 1'h1);
		bitop(8'h95, 2'h2, 1'h0, 1'h0);
		bitop(8'h88, 2'h1, 1'h1, 1'h0);
		bitop(8'h10, 2'h0, 1'h1, 1'h0);
		dump(1'h1);
		for (int i = 0; i < 7; i++) begin
			@(posedge pclk);
			slow <= i[0];
			t = i < 6 ? TT[i] : 16'(16'hEC + $urandom_range(16'hEF3));
			go(t, i == 1 || i == 2 || i == 6);
			finish(i == 1 || i == 2 || i == 6 ? 2'h1 : 2'h2);
		end
		rdchk(12'h240, 8'h01, 1'h0);
		@(posedge pclk);
		slow <= 1'h1;
		go(16'h100, 1'h1);
		go(16'h200, 1'h0);
		finish(2'h3);
		// reset again mid run: pointers and protection return to reset state
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		`CHK("pc_load", 1'h1, pc_load)
		`CHK("stack", 8'h07, stack_top_pointer)
		presetn <= 1'h1;
		@(posedge pclk);
		#1;
		`CHK("pc_load", 1'h0, pc_load)
		rdchk(12'h240, 8'h00, 1'h0);
		rdchk(12'h208, 8'h00, 1'h0);
		give_verdict();
	end
endmodule // tb_program_memory_map_and_pointers
bind pointer_bank pointer_bank_props #(.GO_CODE(GO_CODE)) u_props (.*);
`default_nettype wire
